// [design/dcfpt_fifo.sv]
// fifo with programmable thresholds, cascade pins and replay
`timescale 1ns/1ns
// Functional notes
// - each enabled read edge presents the next stored word unless empty.
// - each write edge with write enable low stores the input word.
// - shared pin gives half full alone, write cascade pulse when chained.
// - empty indicator low when no words, updated on read edges, replay or clear.
// - full indicator low when full, updated on write edges, replay or clear.
// - almost empty low at threshold; free running or on read edges.
// - almost full low at threshold; free running or on write edges.
// - offset access low routes port cycles to threshold registers.
// - chain head select low on first device; standalone it is replay strobe.
// - clear empties the buffer; required after power-up before traffic.
// - after clear falls, output word is all zeros when driving.
// - output drive enable low drives output, high floats it.
// - when chained, only the read token holder drives the output.
// - writes ignored when full, reads ignored when empty.
// - when empty the last validly read word stays on output.
// - store of 4096 words of 18 bits, separate pointers.
// - two 12-bit threshold registers loaded from input bits 0 to 11.
// - threshold loads alternate empty, full, empty on write edges.
// - leaving offset access keeps sequence position for later loads.
// - threshold reads on read edges follow the same alternation.
// - default thresholds are 127 words for this depth.
// - replay pulse returns read pointer to first location.
// - almost flags assert at or within threshold of the boundary.
module dcfpt_fifo
  import dcfpt_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          nrst,
  input  wire logic                          ce,
  input  wire logic                          write_clock,
  input  wire logic                          read_clock,
  input  wire logic                          write_enable_n,
  input  wire logic                          read_enable_n,
  input  wire logic [dcfpt_pkg::DATA_W-1:0]  write_word_in,
  input  wire logic                          offset_access_sel_n,
  input  wire logic                          chip_clear_n,
  input  wire logic                          output_drive_en_n,
  input  wire logic                          sync_thresh_sel,
  input  wire logic                          chain_head_sel,
  input  wire logic                          cascade_wr_in,
  input  wire logic                          cascade_rd_in,
  input  wire logic                          cascade_mode,
  output logic      [dcfpt_pkg::DATA_W-1:0]  read_word_out,
  output logic                               read_word_oe,
  output logic                               empty_ind_n,
  output logic                               full_ind_n,
  output logic                               almost_empty_ind_n,
  output logic                               almost_full_ind_n,
  output logic                               cascade_wr_out,
  output logic                               cascade_rd_out
);
  logic                rst_meta, rst_n;
  logic [PIN_W-1:0]    pin_meta, pin_s;
  logic                wclk_s, rclk_s, we_n_s, re_n_s, ld_n_s, clr_n_s;
  logic                oe_n_s, sync_thresh_sel_s, head_s, wxi_s, rxi_s, casc_s;
  logic [DATA_W-1:0]   wdata_s;
  logic                wclk_q, rclk_q, rt_q;
  logic                wr_edge, rd_edge, replay;
  logic                wr_tok, rd_tok;
  logic                wr_go, rd_go, ld_wr, ld_rd, rd_go_d;
  logic [LEVEL_W-1:0]  wptr, rptr, level, replay_base;
  logic [LEVEL_W-1:0]  next_wptr, next_rptr, next_level;
  logic                next_ae, next_af;
  logic [OFFSET_W-1:0] almost_empty_distance;
  logic [OFFSET_W-1:0] almost_full_distance;
  dcfpt_sel_type       load_sel, show_sel;
  logic [DATA_W-1:0]   store_q;

  // reset release through two flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // every pin crosses two flops before use
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_s    <= '0;
    end else if (ce) begin
      pin_meta <= {write_clock, read_clock, write_enable_n, read_enable_n,
                   offset_access_sel_n, chip_clear_n, output_drive_en_n,
                   sync_thresh_sel, chain_head_sel, cascade_wr_in,
                   cascade_rd_in, cascade_mode, write_word_in};
      pin_s    <= pin_meta;
    end
  end

  assign {wclk_s, rclk_s, we_n_s, re_n_s, ld_n_s, clr_n_s, oe_n_s, sync_thresh_sel_s,
          head_s, wxi_s, rxi_s, casc_s, wdata_s} = pin_s;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wclk_q <= 1'b0;
      rclk_q <= 1'b0;
      rt_q   <= 1'b0;
    end else if (ce) begin
      wclk_q <= wclk_s;
      rclk_q <= rclk_s;
      rt_q   <= head_s;
    end
  end

  assign wr_edge = wclk_s & ~wclk_q;
  assign rd_edge = rclk_s & ~rclk_q;
  assign replay  = head_s & ~rt_q & ~casc_s;

  assign wr_go = wr_edge & ~we_n_s & ld_n_s & clr_n_s & (wr_tok | ~casc_s)
                 & (level != DEPTH_LEVEL);
  assign rd_go = rd_edge & ~re_n_s & ld_n_s & clr_n_s & (rd_tok | ~casc_s)
                 & (level != '0);
  assign ld_wr = wr_edge & ~we_n_s & ~ld_n_s & clr_n_s;
  assign ld_rd = rd_edge & ~re_n_s & ~ld_n_s & clr_n_s;

  assign next_wptr  = wptr + {12'h000, wr_go};
  // rewind to location zero of the lap holding the words; assumes at most one depth
  assign replay_base = (wptr[ADDR_W-1:0] == '0 && wptr != '0) ? (wptr ^ DEPTH_LEVEL)
                       : {wptr[ADDR_W], {ADDR_W{1'b0}}};
  assign next_rptr  = replay ? replay_base : rptr + {12'h000, rd_go};
  assign next_level = next_wptr - next_rptr;
  assign level      = wptr - rptr;
  assign next_ae = next_level <= {1'b0, almost_empty_distance};
  assign next_af = next_level >= DEPTH_LEVEL - {1'b0, almost_full_distance};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
    end else if (ce) begin
      if (!clr_n_s) begin
        wptr <= '0;
        rptr <= '0;
      end else begin
        wptr <= next_wptr;
        rptr <= next_rptr;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_tok <= 1'b0;
      rd_tok <= 1'b0;
    end else if (ce) begin
      if (!clr_n_s) begin
        // head of chain starts holding both tokens
        wr_tok <= ~head_s;
        rd_tok <= ~head_s;
      end else begin
        if (wxi_s) begin
          wr_tok <= 1'b1;
        end else if (wr_go && wptr[ADDR_W-1:0] == LAST_ADDR) begin
          wr_tok <= 1'b0;
        end
        if (rxi_s) begin
          rd_tok <= 1'b1;
        end else if (rd_go && rptr[ADDR_W-1:0] == LAST_ADDR) begin
          rd_tok <= 1'b0;
        end
      end
    end
  end

  // shared pin: half full alone, write hand-off pulse when chained
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cascade_wr_out <= 1'b1;
      cascade_rd_out <= 1'b0;
    end else if (ce) begin
      if (casc_s) begin
        cascade_wr_out <= wr_go & (wptr[ADDR_W-1:0] == LAST_ADDR);
        cascade_rd_out <= rd_go & (rptr[ADDR_W-1:0] == LAST_ADDR);
      end else begin
        cascade_wr_out <= ~(next_level > HALF_LEVEL);
        cascade_rd_out <= 1'b0;
      end
    end
  end

  // empty only moves on read edges, replay or clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      empty_ind_n <= 1'b0;
    end else if (ce) begin
      if (!clr_n_s) begin
        empty_ind_n <= 1'b0;
      end else if (rd_edge || replay) begin
        empty_ind_n <= next_level != '0;
      end
    end
  end

  // full only moves on write edges, replay or clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      full_ind_n <= 1'b1;
    end else if (ce) begin
      if (!clr_n_s) begin
        full_ind_n <= 1'b1;
      end else if (wr_edge || replay) begin
        full_ind_n <= next_level != DEPTH_LEVEL;
      end
    end
  end

  // almost flags, free running when select high
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      almost_empty_ind_n <= 1'b0;
      almost_full_ind_n  <= 1'b1;
    end else if (ce) begin
      if (!clr_n_s) begin
        almost_empty_ind_n <= 1'b0;
        almost_full_ind_n  <= 1'b1;
      end else begin
        if (sync_thresh_sel_s || rd_edge || replay) begin
          almost_empty_ind_n <= ~next_ae;
        end
        if (sync_thresh_sel_s || wr_edge || replay) begin
          almost_full_ind_n <= ~next_af;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      almost_empty_distance <= EMPTY_DIST_RST;
      almost_full_distance  <= FULL_DIST_RST;
      load_sel              <= SEL_EMPTY;
    end else if (ce) begin
      if (!clr_n_s) begin
        almost_empty_distance <= EMPTY_DIST_RST;
        almost_full_distance  <= FULL_DIST_RST;
        load_sel              <= SEL_EMPTY;
      end else if (ld_wr) begin
        case (load_sel)
          SEL_EMPTY: begin
            almost_empty_distance <= wdata_s[OFFSET_W-1:0];
            load_sel              <= SEL_FULL;
          end
          SEL_FULL: begin
            almost_full_distance <= wdata_s[OFFSET_W-1:0];
            load_sel             <= SEL_EMPTY;
          end
          default: begin
            load_sel <= SEL_EMPTY;
          end
        endcase
      end
    end
  end

  dcfpt_store u_store (
    .clock   (clock),
    .ce      (ce),
    .wr_en   (wr_go),
    .wr_addr (wptr[ADDR_W-1:0]),
    .wr_data (wdata_s),
    .rd_en   (rd_go),
    .rd_addr (rptr[ADDR_W-1:0]),
    .rd_data (store_q)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      show_sel <= SEL_EMPTY;
      rd_go_d  <= 1'b0;
    end else if (ce) begin
      rd_go_d <= rd_go;
      if (!clr_n_s) begin
        show_sel <= SEL_EMPTY;
      end else if (ld_rd) begin
        show_sel <= (show_sel == SEL_EMPTY) ? SEL_FULL : SEL_EMPTY;
      end
    end
  end

  // output register only changes on a valid read, a threshold read or clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      read_word_out <= OUT_RST;
    end else if (ce) begin
      if (!clr_n_s) begin
        // zeros after clear falls; seen only while driven
        read_word_out <= OUT_RST;
      end else if (ld_rd) begin
        read_word_out <= {6'h00, (show_sel == SEL_EMPTY) ?
                          almost_empty_distance : almost_full_distance};
      end else if (rd_go_d) begin
        read_word_out <= store_q;
      end
    end
  end

  // output enable, token holder only when chained
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      read_word_oe <= 1'b0;
    end else if (ce) begin
      read_word_oe <= ~oe_n_s & (rd_tok | ~casc_s);
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_write_advances: assert property (
    ce && wr_go |=> wptr == $past(wptr) + 13'h0001)
    else $error("write did not advance pointer");
  a_full_blocks: assert property (
    ce && level == DEPTH_LEVEL && !replay ##0 clr_n_s |=> $stable(wptr))
    else $error("write taken while full");
  a_empty_blocks: assert property (
    ce && level == '0 && !replay && clr_n_s |=> $stable(rptr))
    else $error("read taken while empty");
  a_empty_flag_set: assert property (
    ce && clr_n_s && rd_edge && next_level == '0 |=> !empty_ind_n)
    else $error("empty flag not low");
  a_full_flag_set: assert property (
    ce && clr_n_s && wr_edge && next_level == DEPTH_LEVEL |=> !full_ind_n)
    else $error("full flag not low");
  a_clear_empties: assert property (
    ce && !clr_n_s |=> !empty_ind_n && level == '0)
    else $error("clear did not empty");
  a_clear_zero_out: assert property (
    ce && !clr_n_s |=> read_word_out == OUT_RST)
    else $error("output not zero after clear");
  a_drive_off: assert property (
    ce && oe_n_s |=> !read_word_oe)
    else $error("output driven while disabled");
  a_load_empty_first: assert property (
    ce && ld_wr && load_sel == SEL_EMPTY
    |=> almost_empty_distance == $past(wdata_s[OFFSET_W-1:0]) && load_sel == SEL_FULL)
    else $error("empty threshold not loaded");
  a_read_word_shown: assert property (
    ce && rd_go && !ld_rd ##1 ce && clr_n_s && !ld_rd |=> read_word_out == $past(store_q))
    else $error("read word not presented");
  a_half_full: assert property (
    ce && !casc_s && next_level > HALF_LEVEL |=> !cascade_wr_out)
    else $error("half full not low");

  c_write: cover property (ce && wr_go);
  c_read: cover property (ce && rd_go);
  c_replay: cover property (ce && replay && clr_n_s);
  c_load_both: cover property (ce && ld_wr ##[1:40] ce && ld_wr);
endmodule

// [design/dcfpt_pkg.sv]
// constants and types shared by the dual clock fifo design
package dcfpt_pkg;
  localparam int          DATA_W        = 18;
  localparam int          ADDR_W        = 12;
  localparam int          LEVEL_W       = 13;
  localparam int          OFFSET_W      = 12;
  localparam int          PIN_W         = 30;
  localparam logic [12:0] DEPTH_LEVEL   = 13'h1000;
  localparam logic [12:0] HALF_LEVEL    = 13'h0800;
  localparam logic [11:0] LAST_ADDR     = 12'hFFF;
  localparam logic [11:0] EMPTY_DIST_RST = 12'h07F;
  localparam logic [11:0] FULL_DIST_RST  = 12'h07F;
  localparam logic [17:0] OUT_RST       = 18'h00000;
  typedef enum logic {SEL_EMPTY, SEL_FULL} dcfpt_sel_type;
endpackage

// [design/dcfpt_store.sv]
// word store with registered read data
`timescale 1ns/1ns
module dcfpt_store
  import dcfpt_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          ce,
  input  wire logic                          wr_en,
  input  wire logic [dcfpt_pkg::ADDR_W-1:0]  wr_addr,
  input  wire logic [dcfpt_pkg::DATA_W-1:0]  wr_data,
  input  wire logic                          rd_en,
  input  wire logic [dcfpt_pkg::ADDR_W-1:0]  rd_addr,
  output logic      [dcfpt_pkg::DATA_W-1:0]  rd_data
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // no reset on the array so it maps onto block ram
  always_ff @(posedge clock) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (ce && rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// [test/dcfpt_port_model.sv]
// writer and reader pin model driving the fifo ports
`timescale 1ns/1ns
module dcfpt_port_model
  import dcfpt_pkg::*;
(
  input  wire logic                          clock,
  input  wire logic                          wr_req,
  input  wire logic                          rd_req,
  input  wire logic                          en_n,
  input  wire logic                          slow,
  input  wire logic [dcfpt_pkg::DATA_W-1:0]  word,
  output logic                               write_clock,
  output logic                               read_clock,
  output logic                               write_enable_n,
  output logic                               read_enable_n,
  output logic      [dcfpt_pkg::DATA_W-1:0]  write_word_in,
  output logic                               busy,
  output logic                               rd_done
);
  logic [3:0] step;
  logic       is_rd;
  logic       en_l;

  // pin clocks stand still between frames
  initial begin
    write_clock = 1'b0;
    read_clock = 1'b0;
    write_enable_n = 1'b1;
    read_enable_n = 1'b1;
    write_word_in = 18'h00000;
    busy = 1'b0;
    rd_done = 1'b0;
    step = 4'h0;
  end

  always @(posedge clock) begin
    rd_done <= 1'b0;
    if (!busy) begin
      if (wr_req || rd_req) begin
        busy <= 1'b1;
        step <= 4'h0;
        is_rd <= rd_req;
        en_l <= en_n;
        if (rd_req) begin
          read_enable_n <= en_n;
        end else begin
          write_enable_n <= en_n;
          write_word_in <= word;
        end
      end
    end else begin
      step <= step + 4'h1;
      if (step == 4'h1) begin
        read_clock <= is_rd;
        write_clock <= ~is_rd;
      end
      // pin high two cycles, enough for the sampler
      if (step == 4'h3) begin
        read_clock <= 1'b0;
        write_clock <= 1'b0;
      end
      // released data no longer shows the old word
      if (step == 4'h5) begin
        read_enable_n <= 1'b1;
        write_enable_n <= 1'b1;
        write_word_in <= ~write_word_in;
      end
      if (step == (slow ? 4'hA : 4'h6)) begin
        busy <= 1'b0;
        rd_done <= is_rd & ~en_l;
      end
    end
  end
endmodule

// [test/dual_clock_fifo_prog_thresholds_tb.sv]
// self-checking bench for the dual clock fifo
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module dual_clock_fifo_prog_thresholds_tb;
  import dcfpt_pkg::*;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        chip_clear_n = 1'b1;
  logic        output_drive_en_n = 1'b0;
  logic        offset_access_sel_n = 1'b1;
  logic        sync_thresh_sel = 1'b1;
  logic        chain_head_sel = 1'b0;
  logic        cascade_mode = 1'b0;
  logic        cascade_in = 1'b0;
  logic        wr_req = 1'b0;
  logic        rd_req = 1'b0;
  logic        en_n = 1'b0;
  logic        slow = 1'b0;
  logic [17:0] word = 18'h00000;
  logic        write_clock, read_clock, write_enable_n, read_enable_n, busy, rd_done;
  logic [17:0] write_word_in, read_word_out, w, last, exp_w;
  logic        read_word_oe, empty_ind_n, full_ind_n, almost_empty_ind_n;
  logic        almost_full_ind_n, cascade_wr_out, cascade_rd_out;
  logic [11:0] f1;
  logic [17:0] exp_q[$];
  logic [17:0] model_q[$];
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          i;

  always #4 clock = ~clock;

  dcfpt_fifo uut (
    .clock, .nrst, .ce(1'b1), .write_clock, .read_clock, .write_enable_n,
    .read_enable_n, .write_word_in, .offset_access_sel_n, .chip_clear_n,
    .output_drive_en_n, .sync_thresh_sel, .chain_head_sel, .cascade_wr_in(cascade_in),
    .cascade_rd_in(cascade_in), .cascade_mode, .read_word_out, .read_word_oe,
    .empty_ind_n, .full_ind_n, .almost_empty_ind_n, .almost_full_ind_n,
    .cascade_wr_out, .cascade_rd_out
  );

  dcfpt_port_model partner (
    .clock, .wr_req, .rd_req, .en_n, .slow, .word, .write_clock, .read_clock,
    .write_enable_n, .read_enable_n, .write_word_in, .busy, .rd_done
  );

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic port_op(input logic rd, input logic en, input logic [17:0] d);
    wr_req <= ~rd;
    rd_req <= rd;
    en_n <= en;
    word <= d;
    @(posedge clock);
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    repeat (2) @(posedge clock);
    while (busy) @(posedge clock);
    @(posedge clock);
  endtask

  task automatic rd_exp(input logic [17:0] e);
    exp_q.push_back(e);
    port_op(1'b1, 1'b0, 18'h00000);
  endtask

  // no port cycles while clear is low
  task automatic clear_pulse;
    chip_clear_n <= 1'b0;
    repeat (6) @(posedge clock);
    chip_clear_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask

  always @(posedge clock) begin
    if (rd_done) begin
      exp_w = exp_q.pop_front();
      `CHK(read_word_out, exp_w)
    end
  end

  // long enough for one fill and drain of the store
  always @(posedge clock) begin
    cycles++;
    if (cycles == 95000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    void'($urandom(32'h4FF88179));
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    repeat (6) @(posedge clock);
    clear_pulse();
    `CHK(empty_ind_n, 1'b0)
    `CHK(read_word_out, OUT_RST)
    `CHK(read_word_oe, 1'b1)
    $display("test clear done");
    offset_access_sel_n <= 1'b0;
    w = $urandom;
    port_op(1'b0, 1'b0, w);
    w = $urandom;
    f1 = w[11:0];
    port_op(1'b0, 1'b0, w);
    port_op(1'b0, 1'b0, 18'h3F003);
    rd_exp(18'h00003);
    rd_exp({6'h00, f1});
    offset_access_sel_n <= 1'b1;
    repeat (4) @(posedge clock);
    offset_access_sel_n <= 1'b0;
    port_op(1'b0, 1'b0, 18'h3F005);
    rd_exp(18'h00003);
    rd_exp(18'h00005);
    offset_access_sel_n <= 1'b1;
    $display("test thresholds done");
    for (i = 1; i <= 4096; i++) begin
      w = $urandom;
      model_q.push_back(w);
      port_op(1'b0, 1'b0, w);
      if (i == 1) `CHK(empty_ind_n, 1'b0)
      `CHK(almost_empty_ind_n, 1'(i > 3))
      `CHK(almost_full_ind_n, 1'(i < 4091))
      `CHK(cascade_wr_out, 1'(i <= 2048))
      `CHK(full_ind_n, 1'(i < 4096))
    end
    port_op(1'b0, 1'b0, 18'h2AAAA);
    sync_thresh_sel <= 1'b0;
    port_op(1'b1, 1'b1, 18'h00000);
    `CHK(empty_ind_n, 1'b1)
    rd_exp(model_q.pop_front());
    `CHK(full_ind_n, 1'b0)
    port_op(1'b0, 1'b1, 18'h00000);
    `CHK(full_ind_n, 1'b1)
    while (model_q.size() > 0) begin
      last = model_q.pop_front();
      rd_exp(last);
      `CHK(almost_empty_ind_n, 1'(model_q.size() > 3))
    end
    `CHK(empty_ind_n, 1'b0)
    rd_exp(last);
    $display("test fill and drain done");
    output_drive_en_n <= 1'b1;
    repeat (5) @(posedge clock);
    `CHK(read_word_oe, 1'b0)
    output_drive_en_n <= 1'b0;
    slow <= 1'b1;
    for (i = 0; i < 3; i++) begin
      w = $urandom;
      model_q.push_back(w);
      port_op(1'b0, 1'b0, w);
    end
    for (i = 0; i < 6; i++) begin
      rd_exp(model_q[i % 3]);
      if (i == 2) begin
        `CHK(empty_ind_n, 1'b0)
        // standalone head pin acts as replay
        chain_head_sel <= 1'b1;
        repeat (3) @(posedge clock);
        chain_head_sel <= 1'b0;
        repeat (5) @(posedge clock);
        `CHK(empty_ind_n, 1'b1)
        `CHK(almost_full_ind_n, 1'b1)
      end
    end
    $display("test replay done");
    port_op(1'b0, 1'b0, 18'h12345);
    clear_pulse();
    `CHK(empty_ind_n, 1'b0)
    `CHK(read_word_out, OUT_RST)
    offset_access_sel_n <= 1'b0;
    rd_exp({6'h00, EMPTY_DIST_RST});
    rd_exp({6'h00, FULL_DIST_RST});
    $display("test clear midrun done");
    // chained non-head device starts without the read token
    cascade_mode <= 1'b1;
    chain_head_sel <= 1'b1;
    clear_pulse();
    `CHK(read_word_oe, 1'b0)
    `CHK(cascade_wr_out, 1'b0)
    cascade_in <= 1'b1;
    repeat (3) @(posedge clock);
    cascade_in <= 1'b0;
    repeat (6) @(posedge clock);
    `CHK(read_word_oe, 1'b1)
    $display("test cascade done");
    conclude();
  end
endmodule
